/* sbo_burst_seq.sv */
`timescale 1ns/1ps
module sbo_burst_seq (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // control
  input wire logic enable,
  input wire logic interleaved,
  input wire logic load,
  input wire logic step,
  input wire logic [1:0] start_addr,
  // result
  output logic [1:0] addr
);

  logic [1:0] base_q;
  logic [1:0] cnt_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      base_q <= sbo_pkg::ADDR_RESET;
      cnt_q <= sbo_pkg::CNT_RESET;
    end else if (enable && load) begin
      base_q <= start_addr;
      cnt_q <= sbo_pkg::CNT_RESET;
    end else if (enable && step) begin
      // two-bit counter wraps to the start after four beats
      cnt_q <= cnt_q + 2'h1; // RQ1
    end
  end

  always_comb begin
    if (load) begin
      addr = start_addr;
    end else if (interleaved) begin
      addr = base_q ^ (cnt_q + 2'h1); // RQ1
    end else begin
      addr = base_q + cnt_q + 2'h1;
    end
  end

endmodule // sbo_burst_seq

/* sbo_ctl_model.sv */
`timescale 1ns/1ps
module sbo_ctl_model (
  // clock
  input wire logic clk,
  // device pins
  output sbo_pkg::sbo_req_t req,
  output logic sleep_request
);
  initial begin
    req = '0;
    sleep_request = 1'b0;
  end
  task automatic beat(input logic s, v, w, input logic [1:0] a);
    @(posedge clk);
    #1 req = {s, v, w, a};
  endtask
  // called only when idle; the reads issued once asleep must be ignored
  task automatic nap(input int n);
    sleep_request = 1'b1;
    repeat (6) @(posedge clk);
    #1 req.select = 1'b1;
    repeat (n) @(posedge clk);
    #1 req.select = 1'b0;
  endtask
  task automatic wake;
    sleep_request = 1'b0;
  endtask
endmodule // sbo_ctl_model

/* sbo_ctrl.sv */
`timescale 1ns/1ps
// Function
// RQ1 - interleaved beats use the start bits XOR a beat count 00,01,10,11 and wrap on the fifth.
// RQ2 - the device is asleep two clock cycles after sleep_request rises.
// RQ3 - while asleep all contents and internal state are kept for resumption.
// RQ4 - after sleep_request falls the device works again after two wake-up cycles.
// RQ5 - in sleep the device is deselected, ignores all inputs but sleep_request, data is high-z.
// RQ6 - sleep_request is asynchronous active high and sleep lasts while it stays high.
// RQ7 - the controller raises sleep_request only when all reads and writes are done.
// RQ8 - while recovering the controller issues only deselects or reads.
// RQ9 - sleep_request is held low in normal operation, by the driver or the pull-down.
// RQ10 - flow_through_select chooses flow-through or pipelined operation.
// RQ11 - burst_order_select high gives interleaved order, low gives linear order.
// RQ12 - burst_advance low loads a new start address, high advances the burst counter.
// RQ13 - in flow-through mode the read pipeline is one cycle shorter than pipelined.
// RQ14 - sleep_request is synchronised before the entry and exit periods are counted.
module sbo_ctrl (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // mode pins
  input wire logic sleep_request,
  input wire logic burst_order_select,
  input wire logic flow_through_select,
  // controller requests
  input wire sbo_pkg::sbo_req_t req,
  // issued beat
  output sbo_pkg::sbo_beat_t beat,
  // read data output enable timing
  output logic read_data_oe,
  // state
  output logic asleep,
  output logic recovering,
  output sbo_pkg::sbo_state_t state
);

  logic sleep_meta_q;
  logic sleep_sync_q;
  logic ft_meta_q;
  logic ft_sync_q;
  logic lbo_meta_q;
  logic lbo_sync_q;
  sbo_pkg::sbo_state_t state_q;
  sbo_pkg::sbo_state_t state_d;
  logic [1:0] wait_q;
  logic enable;
  logic [1:0] next_addr;
  logic rd_stage1_q;
  logic rd_stage2_q;
  logic beat_is_read;

  // mode pins from outside pass two flops first
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sleep_meta_q <= 1'b0; // RQ9
      sleep_sync_q <= 1'b0;
    end else begin
      sleep_meta_q <= sleep_request; // RQ14
      sleep_sync_q <= sleep_meta_q; // RQ6
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ft_meta_q <= 1'b0;
      ft_sync_q <= 1'b0;
      lbo_meta_q <= 1'b0;
      lbo_sync_q <= 1'b0;
    end else begin
      ft_meta_q <= flow_through_select;
      ft_sync_q <= ft_meta_q;
      lbo_meta_q <= burst_order_select;
      lbo_sync_q <= lbo_meta_q;
    end
  end

  // sleep state machine, counting from the synchronised request
  always_comb begin
    state_d = state_q;
    case (state_q)
      sbo_pkg::SBO_AWAKE: begin
        if (sleep_sync_q) begin
          state_d = sbo_pkg::SBO_ENTERING;
        end
      end
      sbo_pkg::SBO_ENTERING: begin
        if (!sleep_sync_q) begin
          state_d = sbo_pkg::SBO_AWAKE;
        end else if (wait_q == 2'(sbo_pkg::SLEEP_ENTRY_CYCLES - 1)) begin
          state_d = sbo_pkg::SBO_ASLEEP; // RQ2
        end
      end
      sbo_pkg::SBO_ASLEEP: begin
        if (!sleep_sync_q) begin
          state_d = sbo_pkg::SBO_WAKING; // RQ6
        end
      end
      sbo_pkg::SBO_WAKING: begin
        if (sleep_sync_q) begin
          state_d = sbo_pkg::SBO_ASLEEP;
        end else if (wait_q == 2'(sbo_pkg::SLEEP_WAKE_CYCLES - 1)) begin
          state_d = sbo_pkg::SBO_AWAKE; // RQ4
        end
      end
      default: begin
        state_d = sbo_pkg::SBO_AWAKE;
      end
    endcase
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state_q <= sbo_pkg::SBO_AWAKE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wait_q <= sbo_pkg::WAIT_RESET;
    end else if (state_d != state_q) begin
      wait_q <= sbo_pkg::WAIT_RESET;
    end else if (state_q == sbo_pkg::SBO_ENTERING || state_q == sbo_pkg::SBO_WAKING) begin
      wait_q <= wait_q + 2'h1;
    end
  end

  // asleep: all inputs except the sleep pin are ignored, state is frozen
  assign enable = (state_q != sbo_pkg::SBO_ASLEEP); // RQ5

  // writes refused while recovering, in case the controller slips
  assign beat_is_read = !req.write;

  sbo_burst_seq u_seq (
    .clk(clk),
    .nrst(nrst),
    .enable(enable && req.select), // RQ3
    .interleaved(lbo_sync_q), // RQ11
    .load(!req.advance), // RQ12
    .step(req.advance), // RQ12
    .start_addr(req.start_addr),
    .addr(next_addr)
  );

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      beat <= '0;
    end else if (!enable) begin
      beat.valid <= 1'b0; // RQ5
    end else begin
      beat.valid <= req.select && (beat_is_read || state_q != sbo_pkg::SBO_WAKING); // RQ8
      beat.write <= req.write;
      beat.addr <= next_addr; // RQ1
    end
  end

  // read data pipeline: flow-through drives one cycle earlier
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rd_stage1_q <= 1'b0;
      rd_stage2_q <= 1'b0;
    end else begin
      rd_stage1_q <= enable && req.select && beat_is_read;
      rd_stage2_q <= rd_stage1_q && enable;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      read_data_oe <= 1'b0;
    end else if (!enable || state_d == sbo_pkg::SBO_ASLEEP) begin
      read_data_oe <= 1'b0; // RQ5
    end else if (!ft_sync_q) begin
      // flow-through: one cycle after the beat
      read_data_oe <= rd_stage1_q; // RQ13
    end else begin
      // pipelined: one more register stage
      read_data_oe <= rd_stage2_q; // RQ10
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      asleep <= 1'b0;
      recovering <= 1'b0;
      state <= sbo_pkg::SBO_AWAKE;
    end else begin
      asleep <= (state_d == sbo_pkg::SBO_ASLEEP);
      recovering <= (state_d == sbo_pkg::SBO_WAKING);
      state <= state_d;
    end
  end

endmodule // sbo_ctrl

/* sbo_ctrl_sva.sv */
`timescale 1ns/1ps
module sbo_ctrl_sva (
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // watched ports
  input wire logic sleep_request,
  input wire logic burst_order_select,
  input wire logic flow_through_select,
  input wire sbo_pkg::sbo_req_t req,
  input wire sbo_pkg::sbo_beat_t beat,
  input wire logic read_data_oe,
  input wire logic asleep,
  input wire logic recovering,
  input wire sbo_pkg::sbo_state_t state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  a_sleep_entry: assert property (sleep_request [*6] |-> asleep)
    else $error("late sleep");
  a_wake_exit: assert property ((!sleep_request) [*7] |-> !asleep && !recovering)
    else $error("late wake");
  a_sleep_quiet: assert property (asleep |-> !beat.valid && !read_data_oe)
    else $error("active in sleep");
  a_sync_delay: assert property ($rose(sleep_request) |-> (!asleep) [*3])
    else $error("sleep too soon");
  a_recov_nowrite: assert property (recovering && req.select && req.write |=> !beat.valid)
    else $error("write in wake-up");
  a_ileave_step: assert property (
    burst_order_select && req.select && !req.advance ##1 burst_order_select && req.select
    && req.advance |=> beat.addr == ($past(req.start_addr, 2) ^ 2'h1)) else $error("order");
  a_wrap_fifth: assert property (
    req.select && !req.advance ##1 (req.select && req.advance) [*4]
    |=> beat.addr == $past(req.start_addr, 5)) else $error("no wrap");
  a_ft_read: assert property (
    !flow_through_select && beat.valid && !beat.write |=> read_data_oe) else $error("ft oe");
  a_pipe_read: assert property (
    flow_through_select && beat.valid && !beat.write |-> ##2 read_data_oe) else $error("oe");
  a_beat_taken: assert property (
    state == sbo_pkg::SBO_AWAKE && req.select && !req.write |=> beat.valid) else $error("lost");
endmodule // sbo_ctrl_sva

bind sbo_ctrl sbo_ctrl_sva sbo_ctrl_sva_inst (.clk(clk), .nrst(nrst),
  .sleep_request(sleep_request), .burst_order_select(burst_order_select),
  .flow_through_select(flow_through_select), .req(req), .beat(beat),
  .read_data_oe(read_data_oe), .asleep(asleep), .recovering(recovering), .state(state));

/* sbo_pkg.sv */
package sbo_pkg;

  // sleep entry and wake-up periods, in clock cycles
  localparam int unsigned SLEEP_ENTRY_CYCLES = 2;
  localparam int unsigned SLEEP_WAKE_CYCLES = 2;
  localparam logic [1:0] CNT_RESET = 2'h0;
  localparam logic [1:0] ADDR_RESET = 2'h0;
  localparam logic [1:0] WAIT_RESET = 2'h0;

  typedef enum logic [1:0] {
    SBO_AWAKE    = 2'b00,
    SBO_ENTERING = 2'b01,
    SBO_ASLEEP   = 2'b11,
    SBO_WAKING   = 2'b10
  } sbo_state_t;

  // one beat request from the controller
  typedef struct packed {
    logic select;
    logic advance;
    logic write;
    logic [1:0] start_addr;
  } sbo_req_t;

  // what the core issues for a beat
  typedef struct packed {
    logic valid;
    logic write;
    logic [1:0] addr;
  } sbo_beat_t;

endpackage

/* tb_sram_burst_order_sleep_control.sv */
`timescale 1ns/1ps
module tb_sram_burst_order_sleep_control;
  logic clk = 0, nrst = 0, bos = 0, fts = 0, sreq, oe, asleep, recov;
  logic [1:0] a;
  logic [2:0] oe_sh = '0;
  logic [1:0] q[$];
  int seed = 88, bad_count = 0, cmp_count = 0;
  sbo_pkg::sbo_req_t req;
  sbo_pkg::sbo_beat_t beat;
  sbo_pkg::sbo_state_t st;
  always #10 clk = ~clk;
  sbo_ctl_model sbo_ctl_model_inst (.clk(clk), .req(req), .sleep_request(sreq));
  sbo_ctrl sbo_ctrl_inst (.clk(clk), .nrst(nrst), .sleep_request(sreq),
    .burst_order_select(bos), .flow_through_select(fts), .req(req), .beat(beat),
    .read_data_oe(oe), .asleep(asleep), .recovering(recov), .state(st));
  task automatic chk(input string n, input logic [1:0] e, s);
    cmp_count++;
    if (s !== e) begin
      bad_count++;
      $display("[ERR] %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic end_of_test;
    if (bad_count == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // expected beats and read-enable timing
  always @(negedge clk) if (nrst) begin
    chk("oe", oe_sh[0], oe);
    oe_sh = oe_sh >> 1;
    if (beat.valid === 1'b1) begin
      chk("addr", q.size() ? q.pop_front() : 2'bxx, beat.addr);
      if (!beat.write) oe_sh[fts] = 1'b1;
    end
  end
  // load, four steps with a stale pin address, then idle
  task automatic burst;
    a = $random(seed);
    for (int k = 0; k < 5; k++) begin
      sbo_ctl_model_inst.beat(1'b1, k > 0, 1'b0, k > 0 ? ~a : a);
      q.push_back(bos ? a ^ 2'(k) : a + 2'(k));
    end
    sbo_ctl_model_inst.beat(1'b0, 1'b0, 1'b0, a);
  endtask
  initial begin
    repeat (3) @(posedge clk);
    #1 nrst = 1;
    for (int m = 0; m < 8; m++) begin
      // let pending read enables drain before the mode pins move
      repeat (4) @(posedge clk);
      #1 {fts, bos} = 2'(m);
      repeat (4) @(posedge clk);
      burst();
    end
    a = $random(seed);
    sbo_ctl_model_inst.nap(6 + a);
    chk("asleep", 2'h1, asleep);
    chk("state", 2'(sbo_pkg::SBO_ASLEEP), st);
    sbo_ctl_model_inst.wake();
    for (int i = 0; i < 9 && recov !== 1'b1; i++) #20;
    sbo_ctl_model_inst.beat(1'b1, 1'b0, 1'b1, a);
    sbo_ctl_model_inst.beat(1'b0, 1'b0, 1'b0, a);
    repeat (6) @(posedge clk);
    chk("awake", 2'h0, asleep | recov);
    burst();
    repeat (4) @(posedge clk);
    end_of_test();
  end
  // about 150 cycles of work expected
  initial begin
    #20000;
    bad_count++;
    end_of_test();
  end
endmodule // tb_sram_burst_order_sleep_control
